//--- rtl/hrp_pkg.sv
// constants, offsets and types for the histogram ram port and dac ramp
package hrp_pkg;
    localparam logic [3:0] OFF_DAC_CFG = 4'h5;
    localparam logic [3:0] OFF_ADDR_CNT = 4'h6;
    localparam logic [3:0] OFF_DATA_LO = 4'h8;
    localparam logic [3:0] OFF_DATA_HI = 4'hA;
    localparam logic [3:0] OFF_THR_DAC = 4'hB;

    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 4;
    localparam int RAMP_EN_BIT = 5;
    localparam int CHAN_LSB = 6;
    localparam int CHAN_MSB = 7;

    localparam logic [4:0] DIV_RST = 5'h1F;
    localparam logic RAMP_EN_RST = 1'b0;
    localparam logic [1:0] CHAN_RST = 2'h3;
    localparam logic [7:0] THR_RST = 8'h00;

    localparam logic [1:0] CHAN_TRIG = 2'h0;
    localparam logic [1:0] CHAN_CNT1 = 2'h1;
    localparam logic [1:0] CHAN_CNT2 = 2'h2;
    localparam logic [1:0] CHAN_ANALOG = 2'h3;

    localparam logic [16:0] WORD_STEP = 17'h0_0002;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_VALID = 3'b010,
        ST_WAIT = 3'b011,
        ST_WRITE = 3'b100
    } hrp_state_e;
endpackage : hrp_pkg

//--- rtl/hrp_ram_if.sv
// carrier between port decode and ram access engine
`timescale 1ns/1ps
interface hrp_ram_if;
    logic addr_load;
    logic [15:0] addr_val;
    logic lo_wr;
    logic hi_wr;
    logic hi_rd;
    logic [15:0] wdata;
    logic [31:0] rdata;
    modport port (output addr_load, addr_val, lo_wr, hi_wr, hi_rd, wdata, input rdata);
    modport engine (input addr_load, addr_val, lo_wr, hi_wr, hi_rd, wdata, output rdata);
endinterface : hrp_ram_if

//--- rtl/hrp_ram_engine.sv
// address counter, data handshake and ram sequencing
`timescale 1ns/1ps
module hrp_ram_engine (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mcs_mode_i,
    input wire logic write_mode_i,
    hrp_ram_if.engine bus,
    output logic ram_req_o,
    output logic ram_we_o,
    output logic [16:0] ram_addr_o,
    output logic [31:0] ram_wdata_o,
    input wire logic ram_ack_i,
    input wire logic [31:0] ram_rdata_i,
    output logic data_valid_o,
    output logic write_mode_ready_o
);
    hrp_pkg::hrp_state_e state_r, state_nxt;
    logic [16:0] addr_r, addr_nxt;
    logic [15:0] lo_r, lo_nxt;
    logic [31:0] rdata_r, rdata_nxt, wdata_r, wdata_nxt;
    logic req_r, req_nxt, we_r, we_nxt, dav_r, dav_nxt, wmrdy_r, wmrdy_nxt;
    logic rd_mode, wr_mode;

    assign rd_mode = mcs_mode_i & ~write_mode_i;
    assign wr_mode = write_mode_i & ~mcs_mode_i;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        lo_nxt = lo_r;
        rdata_nxt = rdata_r;
        wdata_nxt = wdata_r;
        req_nxt = req_r;
        we_nxt = we_r;
        dav_nxt = dav_r;
        wmrdy_nxt = wr_mode;
        if (bus.addr_load && state_r != hrp_pkg::ST_WRITE) begin
            addr_nxt = {bus.addr_val, 1'b0};
        end
        case (state_r)
            hrp_pkg::ST_IDLE: begin
                dav_nxt = 1'b0;
                if (rd_mode) begin
                    state_nxt = hrp_pkg::ST_FETCH;
                    req_nxt = 1'b1;
                    we_nxt = 1'b0;
                end else if (wr_mode) begin
                    state_nxt = hrp_pkg::ST_WAIT;
                end
            end
            hrp_pkg::ST_FETCH: begin
                if (ram_ack_i) begin
                    rdata_nxt = ram_rdata_i;
                    req_nxt = 1'b0;
                    dav_nxt = 1'b1;
                    state_nxt = hrp_pkg::ST_VALID;
                end
            end
            hrp_pkg::ST_VALID: begin
                if (!rd_mode) begin
                    dav_nxt = 1'b0;
                    state_nxt = hrp_pkg::ST_IDLE;
                end else if (bus.addr_load) begin
                    dav_nxt = 1'b0;
                    req_nxt = 1'b1;
                    state_nxt = hrp_pkg::ST_FETCH;
                end else if (bus.hi_rd) begin
                    addr_nxt = addr_r + hrp_pkg::WORD_STEP;
                    dav_nxt = 1'b0;
                    req_nxt = 1'b1;
                    state_nxt = hrp_pkg::ST_FETCH;
                end
            end
            hrp_pkg::ST_WAIT: begin
                dav_nxt = 1'b0;
                if (!wr_mode) begin
                    state_nxt = hrp_pkg::ST_IDLE;
                end else if (bus.lo_wr) begin
                    lo_nxt = bus.wdata;
                end else if (bus.hi_wr) begin
                    wdata_nxt = {bus.wdata, lo_r};
                    req_nxt = 1'b1;
                    we_nxt = 1'b1;
                    dav_nxt = 1'b1;
                    state_nxt = hrp_pkg::ST_WRITE;
                end
            end
            hrp_pkg::ST_WRITE: begin
                if (ram_ack_i) begin
                    addr_nxt = addr_r + hrp_pkg::WORD_STEP;
                    req_nxt = 1'b0;
                    we_nxt = 1'b0;
                    dav_nxt = 1'b0;
                    state_nxt = hrp_pkg::ST_WAIT;
                end
            end
            default: begin
                state_nxt = hrp_pkg::ST_IDLE;
                req_nxt = 1'b0;
                dav_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= hrp_pkg::ST_IDLE;
            addr_r <= 17'h0_0000;
            lo_r <= 16'h0000;
            rdata_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            req_r <= 1'b0;
            we_r <= 1'b0;
            dav_r <= 1'b0;
            wmrdy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            lo_r <= lo_nxt;
            rdata_r <= rdata_nxt;
            wdata_r <= wdata_nxt;
            req_r <= req_nxt;
            we_r <= we_nxt;
            dav_r <= dav_nxt;
            wmrdy_r <= wmrdy_nxt;
        end
    end

    assign bus.rdata = rdata_r;
    assign ram_req_o = req_r;
    assign ram_we_o = we_r;
    assign ram_addr_o = addr_r;
    assign ram_wdata_o = wdata_r;
    assign data_valid_o = dav_r;
    assign write_mode_ready_o = wmrdy_r;
endmodule : hrp_ram_engine

//--- rtl/hrp_top.sv
// host i/o port: dac ramp, threshold dacs and histogram ram access
// What this block does
// - dac config register, 8 bit, offset 5
// - divider field, reset 31, paces ramp
// - ramp drives dac when bit 5 set
// - bits 6-7 select threshold channel, reset 3
// - depth select limits ramp, msbs used
// - sweep end reloads ramp with fixed level
// - host selects channel, writes offset 11
// - four values feed thresholds and analog out
// - offset 6 loads address bits 1-16
// - address advances on each high half access
// - low half offset 8, high half 10
// - data valid low while awaiting write pair
// - data valid high when word present
// - depth code 0..3 means 12..9 bits
// - fixed level is restart and low limit
// - write mode ready follows write mode while mcs mode is low
// - data valid flag exported for status
`timescale 1ns/1ps
module hrp_top #(
    parameter int RAMP_W = 12
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    input wire logic mcs_mode_i,
    input wire logic write_mode_i,
    input wire logic time_bin_end_i,
    input wire logic sweep_end_i,
    input wire logic [11:0] fixed_dac_level_i,
    input wire logic [1:0] ramp_depth_select_i,
    output logic [RAMP_W-1:0] dac12_o,
    output logic [7:0] trig_threshold_o,
    output logic [7:0] count1_threshold_o,
    output logic [7:0] count2_threshold_o,
    output logic [7:0] analog_out_o,
    output logic ram_req_o,
    output logic ram_we_o,
    output logic [16:0] ram_addr_o,
    output logic [31:0] ram_wdata_o,
    input wire logic ram_ack_i,
    input wire logic [31:0] ram_rdata_i,
    output logic data_valid_o,
    output logic write_mode_ready_o
);
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    hrp_ram_if ram_bus ();

    // dac configuration fields
    logic [4:0] ramp_step_divider_r, ramp_step_divider_nxt;
    logic ramp_en_r, ramp_en_nxt;
    logic [1:0] threshold_channel_select_r, threshold_channel_select_nxt;
    // quad threshold dac values
    logic [7:0] thr_r [4];
    logic [7:0] thr_nxt [4];
    // ramp generator
    logic [4:0] div_cnt_r, div_cnt_nxt;
    logic [RAMP_W-1:0] ramp_r, ramp_nxt;
    logic [RAMP_W-1:0] ramp_step;
    // carry out of the sum marks a pass beyond full scale
    logic [RAMP_W:0] ramp_sum;
    logic [RAMP_W-1:0] dac_r, dac_nxt;
    // host read data
    logic [15:0] rdata_r, rdata_nxt;
    logic [7:0] cfg_byte;

    assign cfg_byte = {threshold_channel_select_r, ramp_en_r, ramp_step_divider_r};

    // host writes into the config and threshold ports
    always_comb begin
        ramp_step_divider_nxt = ramp_step_divider_r;
        ramp_en_nxt = ramp_en_r;
        threshold_channel_select_nxt = threshold_channel_select_r;
        for (int i = 0; i < 4; i++) begin
            thr_nxt[i] = thr_r[i];
        end
        if (io_wr_i && hit(io_addr_i, hrp_pkg::OFF_DAC_CFG)) begin
            ramp_step_divider_nxt = io_wdata_i[hrp_pkg::DIV_MSB:hrp_pkg::DIV_LSB];
            ramp_en_nxt = io_wdata_i[hrp_pkg::RAMP_EN_BIT];
            threshold_channel_select_nxt =
                io_wdata_i[hrp_pkg::CHAN_MSB:hrp_pkg::CHAN_LSB];
        end
        if (io_wr_i && hit(io_addr_i, hrp_pkg::OFF_THR_DAC)) begin
            thr_nxt[threshold_channel_select_r] = io_wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ramp_step_divider_r <= hrp_pkg::DIV_RST;
            ramp_en_r <= hrp_pkg::RAMP_EN_RST;
            threshold_channel_select_r <= hrp_pkg::CHAN_RST;
            for (int i = 0; i < 4; i++) begin
                thr_r[i] <= hrp_pkg::THR_RST;
            end
        end else begin
            ramp_step_divider_r <= ramp_step_divider_nxt;
            ramp_en_r <= ramp_en_nxt;
            threshold_channel_select_r <= threshold_channel_select_nxt;
            for (int i = 0; i < 4; i++) begin
                thr_r[i] <= thr_nxt[i];
            end
        end
    end

    // step size puts the counted bits at the top of the dac word
    always_comb begin
        ramp_step = '0;
        ramp_step[ramp_depth_select_i] = 1'b1;
        ramp_sum = {1'b0, ramp_r} + {1'b0, ramp_step};
    end

    // ramp counter paced by time bin ends
    always_comb begin
        div_cnt_nxt = div_cnt_r;
        ramp_nxt = ramp_r;
        if (sweep_end_i) begin
            div_cnt_nxt = 5'h00;
            ramp_nxt = fixed_dac_level_i[RAMP_W-1:0];
        end else if (time_bin_end_i) begin
            if (div_cnt_r >= ramp_step_divider_r) begin
                div_cnt_nxt = 5'h00;
                // a pass beyond full scale restarts at the low limit
                if (ramp_sum[RAMP_W]) begin
                    ramp_nxt = fixed_dac_level_i[RAMP_W-1:0];
                end else begin
                    ramp_nxt = ramp_sum[RAMP_W-1:0];
                end
            end else begin
                div_cnt_nxt = div_cnt_r + 5'h01;
            end
        end
        dac_nxt = ramp_en_r ? ramp_nxt : fixed_dac_level_i[RAMP_W-1:0];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            div_cnt_r <= 5'h00;
            ramp_r <= '0;
            dac_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            ramp_r <= ramp_nxt;
            dac_r <= dac_nxt;
        end
    end

    // host read data; threshold port has no readback
    always_comb begin
        rdata_nxt = rdata_r;
        if (io_rd_i) begin
            if (hit(io_addr_i, hrp_pkg::OFF_DAC_CFG)) begin
                rdata_nxt = {8'h00, cfg_byte};
            end else if (hit(io_addr_i, hrp_pkg::OFF_DATA_LO)) begin
                rdata_nxt = ram_bus.rdata[15:0];
            end else if (hit(io_addr_i, hrp_pkg::OFF_DATA_HI)) begin
                rdata_nxt = ram_bus.rdata[31:16];
            end else if (hit(io_addr_i, hrp_pkg::OFF_THR_DAC)) begin
                // write-only ports read back as zero
                rdata_nxt = 16'h0000;
            end else if (hit(io_addr_i, hrp_pkg::OFF_ADDR_CNT)) begin
                rdata_nxt = 16'h0000;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // strobes to the ram engine
    assign ram_bus.addr_load = io_wr_i & hit(io_addr_i, hrp_pkg::OFF_ADDR_CNT);
    assign ram_bus.addr_val = io_wdata_i;
    assign ram_bus.lo_wr = io_wr_i & hit(io_addr_i, hrp_pkg::OFF_DATA_LO);
    assign ram_bus.hi_wr = io_wr_i & hit(io_addr_i, hrp_pkg::OFF_DATA_HI);
    assign ram_bus.hi_rd = io_rd_i & hit(io_addr_i, hrp_pkg::OFF_DATA_HI);
    assign ram_bus.wdata = io_wdata_i;

    hrp_ram_engine u_engine (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .mcs_mode_i(mcs_mode_i),
        .write_mode_i(write_mode_i),
        .bus(ram_bus.engine),
        .ram_req_o(ram_req_o),
        .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o),
        .ram_ack_i(ram_ack_i),
        .ram_rdata_i(ram_rdata_i),
        .data_valid_o(data_valid_o),
        .write_mode_ready_o(write_mode_ready_o)
    );

    assign io_rdata_o = rdata_r;
    assign dac12_o = dac_r;
    assign trig_threshold_o = thr_r[hrp_pkg::CHAN_TRIG];
    assign count1_threshold_o = thr_r[hrp_pkg::CHAN_CNT1];
    assign count2_threshold_o = thr_r[hrp_pkg::CHAN_CNT2];
    assign analog_out_o = thr_r[hrp_pkg::CHAN_ANALOG];
endmodule : hrp_top

//--- tb/hrp_sva.sv
// assertions on the host port block
`timescale 1ns/1ps
module hrp_sva (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic mcs_mode_i,
    input wire logic write_mode_i,
    input wire logic ram_req_o,
    input wire logic ram_we_o,
    input wire logic [16:0] ram_addr_o,
    input wire logic [31:0] ram_wdata_o,
    input wire logic ram_ack_i,
    input wire logic data_valid_o,
    input wire logic write_mode_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_cfg_readback: assert property (
        io_wr_i && io_addr_i == 4'h5 ##1 !io_wr_i ##1 io_rd_i && io_addr_i == 4'h5
        |=> io_rdata_o == {8'h00, $past(io_wdata_i[7:0], 3)}) else $error("bad cfg");
    chk_thr_noread: assert property (
        io_rd_i && io_addr_i == 4'hB |=> io_rdata_o == 16'h0000) else $error("thr read");
    chk_addr_load: assert property (
        io_wr_i && io_addr_i == 4'h6 && !ram_req_o
        |=> ram_addr_o == {$past(io_wdata_i), 1'b0}) else $error("addr load");
    chk_addr_even: assert property (ram_addr_o[0] == 1'b0) else $error("addr odd");
    chk_wr_pair: assert property (
        io_wr_i && io_addr_i == 4'hA && write_mode_ready_o && !data_valid_o && !ram_req_o
        |=> ram_req_o && ram_we_o && ram_wdata_o[31:16] == $past(io_wdata_i))
        else $error("no ram write");
    chk_wr_step: assert property (
        ram_req_o && ram_ack_i && ram_we_o |=> ram_addr_o == $past(ram_addr_o) + 17'h0_0002)
        else $error("write step");
    chk_wait_dv: assert property (
        ram_req_o && ram_ack_i && ram_we_o |=> !data_valid_o [*2]) else $error("dv in wait");
    chk_rd_step: assert property (
        io_rd_i && io_addr_i == 4'hA && data_valid_o && mcs_mode_i && !write_mode_i
        |=> ram_addr_o == $past(ram_addr_o) + 17'h0_0002) else $error("read step");
    chk_rd_valid: assert property (
        ram_req_o && ram_ack_i && !ram_we_o && mcs_mode_i && !write_mode_i && !io_wr_i
        |=> data_valid_o) else $error("dv not set");
    chk_wmrdy_follow: assert property (
        1'b1 |=> write_mode_ready_o == $past(write_mode_i && !mcs_mode_i)) else $error("wmrdy");
endmodule : hrp_sva
bind hrp_top hrp_sva sva_u (.clk_i(clk_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .mcs_mode_i(mcs_mode_i), .write_mode_i(write_mode_i), .ram_req_o(ram_req_o),
    .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o),
    .ram_ack_i(ram_ack_i), .data_valid_o(data_valid_o),
    .write_mode_ready_o(write_mode_ready_o));

//--- tb/hrp_ram_model.sv
// histogram ram model, alternating fast and slow answers
`timescale 1ns/1ps
module hrp_ram_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [16:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [logic [16:0]];
    int cnt = 0;
    int lat = 1;
    initial ack_o = 1'b0;
    initial rdata_o = 32'h0000_0000;
    always @(posedge clk_i) begin
        rdata_o <= ~rdata_o;
        ack_o <= 1'b0;
        if (req_i && !ack_o) begin
            if (cnt >= lat) begin
                ack_o <= 1'b1;
                cnt <= 0;
                lat <= 5 - lat;
                if (we_i) mem[addr_i] = wdata_i;
                else rdata_o <= mem.exists(addr_i) ? mem[addr_i] : {15'h0000, addr_i};
            end else cnt <= cnt + 1;
        end
    end
endmodule : hrp_ram_model

//--- tb/hrp_bench.sv
// self-checking bench for the host port block
`timescale 1ns/1ps
`define CHK(g, e) chk_val(32'(g), 32'(e))
module hrp_bench;
    logic clk_i = 1'b0, reset_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, rd_d = 1'b0;
    logic mcs_mode_i = 1'b0, write_mode_i = 1'b0, time_bin_end_i = 1'b0, sweep_end_i = 1'b0;
    logic ram_req_o, ram_we_o, ram_ack_i, data_valid_o, write_mode_ready_o;
    logic [3:0] io_addr_i = 4'h0;
    logic [15:0] io_wdata_i = 16'h0000, io_rdata_o;
    logic [11:0] fixed_dac_level_i = 12'h000, dac12_o, fl;
    logic [1:0] ramp_depth_select_i = 2'h0;
    logic [7:0] trig_threshold_o, count1_threshold_o, count2_threshold_o, analog_out_o;
    logic [7:0] tv [4];
    logic [16:0] ram_addr_o;
    logic [31:0] ram_wdata_o, ram_rdata_i, seed = 32'h96b4_6b34;
    logic [31:0] dw [3];
    logic [15:0] exp_q [$];
    int err_total = 0, total_checks = 0;
    always #10 clk_i = ~clk_i;
    hrp_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .mcs_mode_i(mcs_mode_i), .write_mode_i(write_mode_i), .time_bin_end_i(time_bin_end_i),
        .sweep_end_i(sweep_end_i), .fixed_dac_level_i(fixed_dac_level_i),
        .ramp_depth_select_i(ramp_depth_select_i), .dac12_o(dac12_o),
        .trig_threshold_o(trig_threshold_o), .count1_threshold_o(count1_threshold_o),
        .count2_threshold_o(count2_threshold_o), .analog_out_o(analog_out_o),
        .ram_req_o(ram_req_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
        .ram_wdata_o(ram_wdata_o), .ram_ack_i(ram_ack_i), .ram_rdata_i(ram_rdata_i),
        .data_valid_o(data_valid_o), .write_mode_ready_o(write_mode_ready_o));
    hrp_ram_model ram_u (.clk_i(clk_i), .req_i(ram_req_o), .we_i(ram_we_o),
        .addr_i(ram_addr_o), .wdata_i(ram_wdata_o), .ack_o(ram_ack_i), .rdata_o(ram_rdata_i));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [11:0] ramp_exp(input logic [11:0] f, input int d);
        logic [12:0] e;
        e = {1'b0, f};
        repeat (2) begin
            if (e + (13'h0001 << d) > 13'h0FFF) e = {1'b0, f};
            else e = e + (13'h0001 << d);
        end
        return e[11:0];
    endfunction : ramp_exp
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk_val
    task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_wr_i <= w;
        io_rd_i <= !w;
        io_wdata_i <= d;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
        io_rd_i <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 16'h0000);
    endtask : rd
    task automatic waitv(input logic v, input logic w);
        int i;
        for (i = 0; i < 200; i++) begin
            @(negedge clk_i);
            if ((w ? write_mode_ready_o : data_valid_o) === v) break;
        end
        if (i == 200) begin
            err_total++;
            give_verdict();
        end
    endtask : waitv
    task automatic pulse(input logic s);
        @(posedge clk_i);
        sweep_end_i <= s;
        time_bin_end_i <= !s;
        @(posedge clk_i);
        sweep_end_i <= 1'b0;
        time_bin_end_i <= 1'b0;
    endtask : pulse
    always @(posedge clk_i) rd_d <= io_rd_i;
    always @(negedge clk_i) begin
        if (rd_d) `CHK(io_rdata_o, exp_q.pop_front());
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(4'h5, 16'h00DF);
        bus(4'h5, 1'b1, 16'h0025);
        rd(4'h5, 16'h0025);
        for (int k = 0; k < 4; k++) begin
            tv[k] = 8'(rnd());
            bus(4'h5, 1'b1, 16'(k << 6));
            bus(4'hB, 1'b1, {8'h00, tv[k]});
        end
        rd(4'hB, 16'h0000);
        @(negedge clk_i);
        `CHK({trig_threshold_o, count1_threshold_o, count2_threshold_o, analog_out_o},
            {tv[0], tv[1], tv[2], tv[3]});
        @(posedge clk_i);
        write_mode_i <= 1'b1;
        waitv(1'b1, 1'b1);
        waitv(1'b0, 1'b0);
        bus(4'h6, 1'b1, 16'h0010);
        for (int w = 0; w < 3; w++) begin
            dw[w] = rnd();
            waitv(1'b0, 1'b0);
            bus(4'h8, 1'b1, dw[w][15:0]);
            bus(4'hA, 1'b1, dw[w][31:16]);
        end
        waitv(1'b0, 1'b0);
        for (int w = 0; w < 3; w++) `CHK(ram_u.mem[17'h0_0020 + 17'(2 * w)], dw[w]);
        @(posedge clk_i);
        write_mode_i <= 1'b0;
        mcs_mode_i <= 1'b1;
        waitv(1'b1, 1'b0);
        bus(4'h6, 1'b1, 16'h0010);
        for (int w = 0; w < 3; w++) begin
            waitv(1'b1, 1'b0);
            rd(4'h8, dw[w][15:0]);
            rd(4'hA, dw[w][31:16]);
        end
        mcs_mode_i <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            @(posedge clk_i);
            fl = 12'(rnd());
            if (d == 2) fl = 12'hFF9;
            fixed_dac_level_i <= fl;
            ramp_depth_select_i <= 2'(d);
            bus(4'h5, 1'b1, 16'h0021);
            pulse(1'b1);
            repeat (4) pulse(1'b0);
            repeat (2) @(negedge clk_i);
            `CHK(dac12_o, ramp_exp(fl, d));
            bus(4'h5, 1'b1, 16'h0001);
            repeat (2) @(negedge clk_i);
            `CHK(dac12_o, fl);
        end
        give_verdict();
    end
endmodule : hrp_bench
